/* core/rmpc_port_coding.sv */
// radio port line coding top: register slave, transmit coder, clocks and pins
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`include "rmpc_consts.svh"
`default_nettype none
module rmpc_port_coding #(
  parameter int unsigned VHF_MARK_HALF = `RMPC_HCLK_HZ / (2 * `RMPC_VHF_MARK_HZ),
  parameter int unsigned VHF_SPACE_HALF = `RMPC_HCLK_HZ / (2 * `RMPC_VHF_SPACE_HZ),
  parameter int unsigned HF_MARK_HALF = `RMPC_HCLK_HZ / (2 * `RMPC_HF_MARK_HZ),
  parameter int unsigned HF_SPACE_HALF = `RMPC_HCLK_HZ / (2 * `RMPC_HF_SPACE_HZ)
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic modem_ready_n,
  input wire logic carrier_detect_n,
  input wire logic tx_clk16_in,
  output logic tx_clk16_out,
  output logic rts_n,
  input wire logic tx_key_a_n,
  input wire logic tx_key_b_n,
  output logic ptt_n,
  output logic tx_data_out,
  input wire logic line_code_select_jumper,
  input wire logic band_select_switch,
  input wire logic rx_line_in,
  output logic rx_clk_out,
  output logic rx_nrz_out,
  output logic dcd_o,
  output logic dcd_oe,
  output logic tone_out
);
  import rmpc_pkg::*;

  rmpc_top_state_t q, d;
  rmpc_link_if lnk ();
  logic ck_rise, bit_end, addr_ph;

  rmpc_nrzi_rx u_rx (
    .link_clk(link_clk),
    .hresetn(hresetn),
    .rx_line(rx_line_in),
    .lnk(lnk.rx_src)
  );

  rmpc_tone_gen #(
    .VM(VHF_MARK_HALF),
    .VS(VHF_SPACE_HALF),
    .HM(HF_MARK_HALF),
    .HS(HF_SPACE_HALF)
  ) u_tone (
    .hclk(hclk),
    .hresetn(hresetn),
    .lnk(lnk.tone_gen)
  );

  // new line level for one bit: a zero flips the level, a one holds it
  function automatic logic nrzi_next(input logic bit_in, input logic level);
    return bit_in ? level : ~level;
  endfunction

  // read mux; reserved bits and unmapped words read zero
  function automatic logic [31:0] read_word(input logic [7:0] ofs, input rmpc_top_state_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (ofs)
      `RMPC_OFS_CTRL: w = 32'h0000_0000;
      `RMPC_OFS_DIV: w = {16'h0000, s.div};
      `RMPC_OFS_TXDATA: w = {24'h00_0000, s.txbyte};
      `RMPC_OFS_STATUS: w = {16'h0000, s.rxcnt, 2'b00, s.lc_s2, s.band_s2,
                             ~s.cd_s2, ~s.cts_s2, s.rts_n, (s.st != TX_IDLE)};
      `RMPC_OFS_RXDATA: w = {24'h00_0000, s.rxsh};
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  always_comb begin
    d = q;
    // pin synchronisers, two stages before any use
    d.cts_s1 = modem_ready_n;
    d.cts_s2 = q.cts_s1;
    d.ck_s1 = tx_clk16_in;
    d.ck_s2 = q.ck_s1;
    d.ck_s3 = q.ck_s2;
    d.cd_s1 = carrier_detect_n;
    d.cd_s2 = q.cd_s1;
    d.band_s1 = band_select_switch;
    d.band_s2 = q.band_s1;
    d.lc_s1 = line_code_select_jumper;
    d.lc_s2 = q.lc_s1;
    d.ka_s1 = tx_key_a_n;
    d.ka_s2 = q.ka_s1;
    d.kb_s1 = tx_key_b_n;
    d.kb_s2 = q.kb_s1;
    d.tg_s1 = lnk.bit_tgl;
    d.tg_s2 = q.tg_s1;
    d.tg_s3 = q.tg_s2;
    ck_rise = q.ck_s2 & ~q.ck_s3;
    bit_end = ck_rise && (q.sub == `RMPC_SUB_LAST);

    // bus slave: no wait states, always okay
    d.rdy = 1'b1;
    d.resp = 1'b0;
    addr_ph = hsel && hready && htrans[1];
    d.a_act = addr_ph;
    d.a_wr = hwrite;
    d.a_ok = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
    d.a_addr = haddr[7:0];
    d.rdata = 32'h0000_0000;
    if (addr_ph && !hwrite && d.a_ok) begin
      d.rdata = read_word(haddr[7:0], q);
    end

    if (q.a_act && q.a_wr && q.a_ok) begin
      unique case (q.a_addr)
        `RMPC_OFS_CTRL: begin
          if (hwdata[`RMPC_CTRL_START] && q.st == TX_IDLE) begin
            // request to send once a frame is queued
            d.st = TX_WAIT;
            d.rts_n = 1'b0;
            d.shreg = q.txbyte;
          end
        end
        // a zero divisor would stall the clock, so it is held at one
        `RMPC_OFS_DIV: d.div = (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
        `RMPC_OFS_TXDATA: d.txbyte = hwdata[7:0];
        default: d.div = q.div;
      endcase
    end

    if (q.clkdiv >= q.div - 16'h0001) begin
      d.clkdiv = 16'h0000;
      d.clk16 = ~q.clk16;
    end else begin
      d.clkdiv = q.clkdiv + 16'h0001;
    end

    unique case (q.st)
      TX_IDLE: begin
        d.sub = 4'h0;
        d.bitn = 3'h0;
      end
      TX_WAIT: begin
        if (!q.cts_s2) begin
          d.st = TX_SEND;
          d.sub = 4'h0;
          d.bitn = 3'h0;
          d.line = nrzi_next(q.shreg[0], q.line);
          d.txd = q.lc_s2 ? d.line : q.shreg[0];
        end
      end
      TX_SEND: begin
        // bit pacing from the outside clock
        if (ck_rise) begin
          d.sub = q.sub + 4'h1;
        end
        if (bit_end) begin
          if (q.bitn == `RMPC_BIT_LAST) begin
            d.st = TX_IDLE;
            d.rts_n = 1'b1;
          end else begin
            d.bitn = q.bitn + 3'h1;
            d.shreg = {1'b0, q.shreg[7:1]};
            d.line = nrzi_next(q.shreg[1], q.line);
            d.txd = q.lc_s2 ? d.line : q.shreg[1];
          end
        end
      end
      default: begin
        d.st = TX_IDLE;
        d.rts_n = 1'b1;
      end
    endcase

    if (q.tg_s2 ^ q.tg_s3) begin
      d.rxsh = {lnk.bit_val, q.rxsh[7:1]};
      d.rxcnt = q.rxcnt + 8'h01;
    end

    // pulled low unless carrier is valid
    d.dcd_o = 1'b0;
    d.dcd_oe = q.cd_s2;
    // key lines act as one wired net
    d.keyed = ~(q.ka_s2 & q.kb_s2);
    // own flop so the key pin carries no gate delay
    d.ptt_n = q.ka_s2 & q.kb_s2;
    d.mark = q.txd;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '{st: TX_IDLE, rts_n: 1'b1, rdy: 1'b1, cts_s1: 1'b1, cts_s2: 1'b1,
             cd_s1: 1'b1, cd_s2: 1'b1, ka_s1: 1'b1, ka_s2: 1'b1, kb_s1: 1'b1,
             kb_s2: 1'b1, dcd_oe: 1'b1, ptt_n: 1'b1, div: 16'(`RMPC_DIV_RST),
             default: '0};
    end else begin
      q <= d;
    end
  end

  // tone set follows the band switch
  assign lnk.band_hf = q.band_s2;
  assign lnk.tone_en = q.keyed;
  assign lnk.tone_mark = q.mark;

  assign hreadyout = q.rdy;
  assign hresp = q.resp;
  assign hrdata = q.rdata;
  assign tx_clk16_out = q.clk16;
  assign rts_n = q.rts_n;
  assign ptt_n = q.ptt_n;
  assign tx_data_out = q.txd;
  // recovered clock handed to the controller side
  assign rx_clk_out = lnk.rclk;
  assign rx_nrz_out = lnk.rnrz;
  assign dcd_o = q.dcd_o;
  assign dcd_oe = q.dcd_oe;
  assign tone_out = lnk.tone;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_wait_blocked;
    q.st == TX_WAIT && q.cts_s2;
  endsequence

  sequence s_wait_ready;
    q.st == TX_WAIT && !q.cts_s2;
  endsequence

  sequence s_bit_advance;
    q.st == TX_SEND && q.ck_s2 && !q.ck_s3 && q.sub == `RMPC_SUB_LAST && q.bitn != `RMPC_BIT_LAST;
  endsequence

  a_tx_holdoff: assert property (
    s_wait_blocked |=> q.st == TX_WAIT && q.rts_n == 1'b0)
    else $error("transmission started while modem not ready");

  a_tx_go: assert property (
    s_wait_ready |=> q.st == TX_SEND ##1 q.st == TX_SEND || q.st == TX_IDLE)
    else $error("ready modem did not start the frame");

  a_rts_keying: assert property (
    q.rts_n == (q.st == TX_IDLE))
    else $error("request to send does not follow transmit state");

  a_clk16_edge: assert property (
    (q.clkdiv >= q.div - 16'h0001) |=> q.clk16 != $past(q.clk16) && q.clkdiv == 16'h0000)
    else $error("sixteen-times clock missed its toggle");

  a_clk16_hold: assert property (
    (q.clkdiv < q.div - 16'h0001) |=> $stable(q.clk16))
    else $error("sixteen-times clock toggled early");

  a_sub_pace: assert property (
    (q.st == TX_SEND && !(q.ck_s2 && !q.ck_s3)) |=> $stable(q.sub) && $stable(q.txd))
    else $error("bit phase moved without a transmit clock edge");

  a_nrzi_code: assert property (
    (s_bit_advance and q.lc_s2) |=> q.txd == ($past(q.line) ^ ~$past(q.shreg[1])))
    else $error("nrzi level wrong for the bit");

  a_nrz_code: assert property (
    (s_bit_advance and !q.lc_s2) |=> q.txd == $past(q.shreg[1]))
    else $error("nrz output not equal to the bit");

  a_frame_len: assert property (
    (q.st == TX_SEND && q.ck_s2 && !q.ck_s3 && q.sub == `RMPC_SUB_LAST
     && q.bitn == `RMPC_BIT_LAST) |=> q.st == TX_IDLE && q.rts_n)
    else $error("frame did not end after eight bits");

  a_dcd_pull: assert property (
    q.cd_s2 |=> q.dcd_oe && !q.dcd_o)
    else $error("carrier output not pulled low without carrier");

  a_dcd_release: assert property (
    !q.cd_s2 |=> !q.dcd_oe)
    else $error("carrier output not released with carrier");

  a_key_common: assert property (
    (!q.ka_s2 || !q.kb_s2) |=> q.keyed && !ptt_n)
    else $error("either key line must key the modem");

  a_bus_okay: assert property (
    hreadyout && !hresp)
    else $error("slave must be ready and okay");

  a_rts_start: assert property (
    (q.a_act && q.a_wr && q.a_ok && q.a_addr == `RMPC_OFS_CTRL
     && hwdata[`RMPC_CTRL_START] && q.st == TX_IDLE) |=> !q.rts_n && q.st == TX_WAIT)
    else $error("start did not request to send");

  a_first_nrz: assert property (
    (s_wait_ready and !q.lc_s2) |=> q.txd == $past(q.shreg[0]))
    else $error("first nrz bit wrong");

  a_rx_gather: assert property (
    (q.tg_s2 ^ q.tg_s3) |=> q.rxsh[7] == $past(lnk.bit_val)
    && q.rxcnt == $past(q.rxcnt) + 8'h01)
    else $error("received bit not gathered");

  a_read_idle: assert property (
    !(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0000_0000)
    else $error("read data outside its data phase");

  a_ptt_key: assert property (
    (q.ka_s2 && q.kb_s2) |=> ptt_n && !q.keyed)
    else $error("key released but still keyed");

endmodule // rmpc_port_coding
`default_nettype wire

/* core/rmpc_consts.svh */
// constants for the radio modem port coding block
`ifndef RMPC_CONSTS_SVH
`define RMPC_CONSTS_SVH
`define RMPC_HCLK_HZ 20000000
`define RMPC_OVERSAMPLE 16
`define RMPC_BAUD_DEF 1200
`define RMPC_VHF_MARK_HZ 1200
`define RMPC_VHF_SPACE_HZ 2200
`define RMPC_HF_MARK_HZ 1600
`define RMPC_HF_SPACE_HZ 1800
`define RMPC_DIV_RST (`RMPC_HCLK_HZ / (2 * `RMPC_OVERSAMPLE * `RMPC_BAUD_DEF))
`define RMPC_OFS_CTRL 8'h00
`define RMPC_OFS_DIV 8'h04
`define RMPC_OFS_TXDATA 8'h08
`define RMPC_OFS_STATUS 8'h0C
`define RMPC_OFS_RXDATA 8'h10
`define RMPC_CTRL_START 0
`define RMPC_SUB_LAST 4'hF
`define RMPC_BIT_LAST 3'h7
`define RMPC_RX_CENTER 4'h7
`define RMPC_RCLK_RISE 4'hC
`define RMPC_RCLK_FALL 4'h4
`endif

/* core/rmpc_pkg.sv */
// types of the radio modem port coding block
`default_nettype none
package rmpc_pkg;
  typedef enum logic [2:0] {TX_IDLE = 3'b001, TX_WAIT = 3'b010, TX_SEND = 3'b100} rmpc_tx_st_t;
  typedef enum logic [1:0] {RX_HUNT = 2'b01, RX_TRACK = 2'b10} rmpc_rx_st_t;
  typedef struct packed {
    logic s1, s2, prev, refl, tgl, val, rclk, rnrz;
    logic [3:0] cnt;
    rmpc_rx_st_t st;
  } rmpc_rx_state_t;
  typedef struct packed {
    logic [15:0] cnt;
    logic tone;
  } rmpc_tone_state_t;
  typedef struct packed {
    logic cts_s1, cts_s2, ck_s1, ck_s2, ck_s3, cd_s1, cd_s2;
    logic band_s1, band_s2, lc_s1, lc_s2, tg_s1, tg_s2, tg_s3;
    logic ka_s1, ka_s2, kb_s1, kb_s2;
    logic a_act, a_wr, a_ok;
    logic [7:0] a_addr;
    logic [31:0] rdata;
    logic rdy, resp;
    logic [15:0] div, clkdiv;
    logic clk16;
    logic [7:0] txbyte, shreg, rxsh, rxcnt;
    logic [2:0] bitn;
    logic [3:0] sub;
    logic line, txd, rts_n, dcd_o, dcd_oe, keyed, mark, ptt_n;
    rmpc_tx_st_t st;
  } rmpc_top_state_t;
endpackage : rmpc_pkg
`default_nettype wire

/* core/rmpc_link_if.sv */
// signals between the top and its receive and tone modules
`default_nettype none
interface rmpc_link_if;
  logic bit_tgl, bit_val, rclk, rnrz, tone_en, tone_mark, band_hf, tone;
  modport rx_src(output bit_tgl, bit_val, rclk, rnrz);
  modport rx_dst(input bit_tgl, bit_val, rclk, rnrz);
  modport tone_ctl(output tone_en, tone_mark, band_hf, input tone);
  modport tone_gen(input tone_en, tone_mark, band_hf, output tone);
endinterface : rmpc_link_if
`default_nettype wire

/* core/rmpc_nrzi_rx.sv */
// receive line decoder and bit clock recovery on the link clock
`include "rmpc_consts.svh"
`default_nettype none
module rmpc_nrzi_rx (
  input wire logic link_clk,
  input wire logic hresetn,
  input wire logic rx_line,
  rmpc_link_if.rx_src lnk
);
  import rmpc_pkg::*;
  logic [1:0] rs_q;
  rmpc_rx_state_t q, d;
  logic edge_seen;
  // reset released in step with the link clock
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) rs_q <= 2'b00;
    else rs_q <= {rs_q[0], 1'b1};
  end
  always_comb begin
    d = q;
    d.s1 = rx_line;
    d.s2 = q.s1;
    d.prev = q.s2;
    edge_seen = q.s2 ^ q.prev;
    if (edge_seen) begin
      d.cnt = 4'h0;
      d.st = RX_TRACK;
    end else begin
      d.cnt = q.cnt + 4'h1;
    end
    if (q.st == RX_TRACK && !edge_seen && q.cnt == `RMPC_RX_CENTER) begin
      d.val = (q.s2 == q.refl);
      d.rnrz = d.val;
      d.refl = q.s2;
      d.tgl = ~q.tgl;
    end
    // data settles mid-bit, the clock rises later so the controller samples cleanly
    d.rclk = (d.st == RX_TRACK) && (d.cnt >= `RMPC_RCLK_RISE || d.cnt < `RMPC_RCLK_FALL);
  end
  always_ff @(posedge link_clk or negedge rs_q[1]) begin
    if (!rs_q[1]) q <= '{st: RX_HUNT, cnt: 4'h0, default: 1'b0};
    else q <= d;
  end
  assign lnk.bit_tgl = q.tgl;
  assign lnk.bit_val = q.val;
  assign lnk.rclk = q.rclk;
  assign lnk.rnrz = q.rnrz;
  a_rx_realign: assert property (
    @(posedge link_clk) disable iff (!rs_q[1]) (q.s2 ^ q.prev) |=> q.cnt == 4'h0)
    else $error("bit phase not realigned at transition");
  a_rx_bit_out: assert property (
    @(posedge link_clk) disable iff (!rs_q[1])
    (q.st == RX_TRACK && !(q.s2 ^ q.prev) && q.cnt == `RMPC_RX_CENTER)
    |=> q.tgl != $past(q.tgl) && q.val == ($past(q.s2) == $past(q.refl)))
    else $error("decoded bit missing or wrong");
endmodule // rmpc_nrzi_rx
`default_nettype wire

/* core/rmpc_tone_gen.sv */
// mark and space tone square wave for the two band settings
`default_nettype none
module rmpc_tone_gen #(
  parameter int unsigned VM = 8333,
  parameter int unsigned VS = 4545,
  parameter int unsigned HM = 6250,
  parameter int unsigned HS = 5555
) (
  input wire logic hclk,
  input wire logic hresetn,
  rmpc_link_if.tone_gen lnk
);
  import rmpc_pkg::*;
  rmpc_tone_state_t q, d;
  // half period per band and tone
  function automatic logic [15:0] half_cnt(input logic hf, input logic mark);
    int unsigned v;
    v = hf ? (mark ? HM : HS) : (mark ? VM : VS);
    return 16'(v - 1);
  endfunction
  always_comb begin
    d = q;
    if (!lnk.tone_en) begin
      d.cnt = 16'h0000;
      d.tone = 1'b0;
    end else if (q.cnt == 16'h0000) begin
      d.cnt = half_cnt(lnk.band_hf, lnk.tone_mark);
      d.tone = ~q.tone;
    end else begin
      d.cnt = q.cnt - 16'h0001;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) q <= '0;
    else q <= d;
  end
  assign lnk.tone = q.tone;
  a_vhf_tones: assert property (
    @(posedge hclk) disable iff (!hresetn) (lnk.tone_en && !lnk.band_hf && q.cnt == 16'h0000)
    |=> q.cnt == 16'(($past(lnk.tone_mark) ? VM : VS) - 1))
    else $error("vhf tone half period wrong");
  a_hf_tones: assert property (
    @(posedge hclk) disable iff (!hresetn) (lnk.tone_en && lnk.band_hf && q.cnt == 16'h0000)
    |=> q.cnt == 16'(($past(lnk.tone_mark) ? HM : HS) - 1))
    else $error("hf tone half period wrong");
endmodule // rmpc_tone_gen
`default_nettype wire

/* verification/rmpc_modem_model.sv */
// audio modem model facing the radio port pins
`default_nettype none
module rmpc_modem_model (
  input wire logic hclk,
  input wire logic link_clk,
  output logic modem_ready_n,
  output logic carrier_detect_n,
  output logic rx_line_in
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    modem_ready_n = 1'b1;
    carrier_detect_n = 1'b1;
    rx_line_in = 1'b0;
  end
  // carrier level: high means no carrier
  task set_pins(input logic rdy_n, input logic cd_n);
    @(posedge hclk);
    modem_ready_n <= rdy_n;
    carrier_detect_n <= cd_n;
  endtask
  // bit pacing: one line change per zero bit, 16 oversample clocks apart
  task send_zeros(input int n);
    repeat (n) begin
      repeat (16) @(posedge link_clk);
      rx_line_in <= ~rx_line_in;
    end
  endtask
endmodule // rmpc_modem_model
`default_nettype wire

/* verification/rmpc_port_coding_test.sv */
// self-checking bench for the radio port coding block
`include "rmpc_consts.svh"
`default_nettype none
`define CHK(nm, e, a) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("unexpected %s exp %h got %h", nm, e, a); end end
module rmpc_port_coding_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, link_clk = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, modem_ready_n, carrier_detect_n, tx_clk16_out, rts_n, ptt_n;
  logic tx_key_a_n = 1'b1, tx_key_b_n = 1'b1, tx_data_out, rx_line_in, rx_clk_out;
  logic line_code_select_jumper = 1'b1, band_select_switch = 1'b0, rx_nrz_out;
  logic dcd_o, dcd_oe, tone_out;
  // nrzi level runs on through nrz frames too
  logic nrzi_lvl = 1'b0;
  int error_cnt = 0, check_count = 0, rises = 0, n;
  always #25 hclk = ~hclk;
  initial begin
    #3;
    forever #6 link_clk = ~link_clk;
  end
  always @(posedge rx_clk_out) rises++;
  // the 16x output is jumpered straight back into the coder, as on board
  rmpc_port_coding #(.VHF_MARK_HALF(8), .VHF_SPACE_HALF(5), .HF_MARK_HALF(6),
    .HF_SPACE_HALF(7)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .link_clk(link_clk), .modem_ready_n(modem_ready_n),
    .carrier_detect_n(carrier_detect_n), .tx_clk16_in(tx_clk16_out),
    .tx_clk16_out(tx_clk16_out), .rts_n(rts_n), .tx_key_a_n(tx_key_a_n),
    .tx_key_b_n(tx_key_b_n), .ptt_n(ptt_n), .tx_data_out(tx_data_out),
    .line_code_select_jumper(line_code_select_jumper),
    .band_select_switch(band_select_switch), .rx_line_in(rx_line_in),
    .rx_clk_out(rx_clk_out), .rx_nrz_out(rx_nrz_out), .dcd_o(dcd_o), .dcd_oe(dcd_oe),
    .tone_out(tone_out));
  rmpc_modem_model modem_u (.hclk(hclk), .link_clk(link_clk),
    .modem_ready_n(modem_ready_n), .carrier_detect_n(carrier_detect_n),
    .rx_line_in(rx_line_in));
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= w ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("hresp", 1'b0, hresp)
  endtask
  function logic sg(bit s);
    return s ? tone_out : tx_clk16_out;
  endfunction
  // stand time of one level, in hclk cycles
  task half(input bit s);
    logic v;
    @(posedge hclk);
    v = sg(s);
    for (int i = 0; i < 999 && sg(s) === v; i++) @(posedge hclk);
    v = sg(s);
    n = 0;
    for (int i = 0; i < 999 && sg(s) === v; i++) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task frame(input logic [7:0] d, input logic j);
    logic lvl, e;
    line_code_select_jumper <= j;
    ahb(1, `RMPC_OFS_TXDATA, {24'h0, d});
    lvl = tx_data_out;
    ahb(1, `RMPC_OFS_CTRL, 32'h1);
    repeat (40) @(posedge hclk);
    `CHK("rts_n low", 1'b0, rts_n)
    `CHK("held line", lvl, tx_data_out)
    ahb(0, `RMPC_OFS_STATUS, 0);
    `CHK("busy", 1'b1, rd[0])
    @(posedge tx_clk16_out);
    modem_u.set_pins(1'b0, 1'b1);
    repeat (8) @(posedge tx_clk16_out);
    for (int i = 0; i < 8; i++) begin
      #1;
      if (!d[i]) nrzi_lvl = ~nrzi_lvl;
      e = j ? nrzi_lvl : d[i];
      `CHK("tx bit", e, tx_data_out)
      if (i < 7) repeat (16) @(posedge tx_clk16_out);
    end
    for (int i = 0; i < 400 && rts_n !== 1'b1; i++) @(posedge hclk);
    `CHK("rts_n high", 1'b1, rts_n)
    modem_u.set_pins(1'b1, 1'b1);
  endtask
  task results;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK("ptt idle", 1'b1, ptt_n)
    // let the pin synchronisers settle before status is read
    repeat (3) @(posedge hclk);
    ahb(0, `RMPC_OFS_STATUS, 0);
    `CHK("status", 32'h22, rd & 32'h23)
    ahb(0, `RMPC_OFS_DIV, 0);
    `CHK("div reset", 32'h208, rd)
    ahb(0, 8'h20, 0);
    `CHK("unmapped", 32'h0, rd)
    ahb(1, `RMPC_OFS_DIV, 32'h0);
    ahb(0, `RMPC_OFS_DIV, 0);
    `CHK("div min", 32'h1, rd)
    ahb(1, `RMPC_OFS_DIV, 32'h4);
    half(0);
    half(0);
    `CHK("clk16 half", 4, n)
    frame(8'h4E, 1'b1);
    frame(8'hB1, 1'b0);
    frame(8'h0F, 1'b1);
    // space tone per band (the frames leave the line low), keyed by either key input
    for (int b = 0; b < 2; b++) begin
      band_select_switch <= b[0];
      if (b == 0) tx_key_a_n <= 1'b0;
      else tx_key_b_n <= 1'b0;
      repeat (6) @(posedge hclk);
      `CHK("ptt keyed", 1'b0, ptt_n)
      half(1);
      half(1);
      `CHK("tone", b ? (tx_data_out ? 6 : 7) : (tx_data_out ? 8 : 5), n)
      tx_key_a_n <= 1'b1;
      tx_key_b_n <= 1'b1;
      repeat (6) @(posedge hclk);
      `CHK("ptt free", 1'b1, ptt_n)
    end
    modem_u.set_pins(1'b1, 1'b0);
    repeat (6) @(posedge hclk);
    `CHK("dcd valid", 2'b00, {dcd_oe, dcd_o})
    modem_u.set_pins(1'b1, 1'b1);
    repeat (6) @(posedge hclk);
    `CHK("dcd none", 2'b10, {dcd_oe, dcd_o})
    fork
      modem_u.send_zeros(25);
    join_none
    repeat (288) @(posedge link_clk);
    `CHK("rx zero", 1'b0, rx_nrz_out)
    ahb(0, `RMPC_OFS_RXDATA, 0);
    `CHK("rxdata zeros", 32'h0, rd & 32'hFF)
    repeat (320) @(posedge link_clk);
    `CHK("rx one", 1'b1, rx_nrz_out)
    ahb(0, `RMPC_OFS_RXDATA, 0);
    `CHK("rxdata ones", 32'hFF, rd & 32'hFF)
    `CHK("rx clock", 1'b1, rises > 16)
    results();
  end
endmodule // rmpc_port_coding_test
`default_nettype wire
